// *** pkg/blvr_pkg.sv ***
// Package: register map, field layout, reset values and decode types for the limit/vout bank
package blvr_pkg;

	// ========================================
	// Register offsets
	localparam logic [7:0] CORE1_LIMIT_ADDR = 8'h05;
	localparam logic [7:0] CORE2_LIMIT_ADDR = 8'h07;
	localparam logic [7:0] CORE3_LIMIT_ADDR = 8'h09;
	localparam logic [7:0] CORE0_VOUT_ADDR  = 8'h0A;
	localparam logic [7:0] CORE0_FLOOR_ADDR = 8'h0B;

	// ========================================
	// Field positions and reset values
	localparam int         LIMIT_LSB        = 3;
	localparam int         LIMIT_MSB        = 5;
	localparam logic [7:0] LIMIT_CTRL_RESET = 8'h3A;
	localparam logic [7:0] VOUT_RESET       = 8'h61;
	localparam logic [7:0] FLOOR_RESET      = 8'h00;
	localparam int         NUM_LIMIT_REGS   = 3;

	// ========================================
	// Current limit decode, milliamps
	localparam logic [12:0] LIMIT_BASE_MA   = 13'h05DC;
	localparam logic [12:0] LIMIT_STEP_MA   = 13'h01F4;

	// ========================================
	// Voltage decode, millivolts (range 2 constants doubled, in half-millivolts)
	localparam logic [7:0]  VRANGE1_LAST    = 8'h17;
	localparam logic [7:0]  VRANGE2_FIRST   = 8'h18;
	localparam logic [7:0]  VRANGE2_LAST    = 8'h9D;
	localparam logic [7:0]  VRANGE3_FIRST   = 8'h9E;
	localparam logic [12:0] VRANGE1_BASE_UV = 13'h01F4; // in mV: 500
	localparam logic [12:0] VRANGE1_STEP    = 13'h000A; // 10 mV
	localparam logic [12:0] VRANGE2_BASE_X2 = 13'h05BE; // 735 mV doubled: 1470
	localparam logic [12:0] VRANGE2_STEP_X2 = 13'h000A; // 5 mV doubled
	localparam logic [12:0] VRANGE3_BASE    = 13'h058C; // 1420 mV
	localparam logic [12:0] VRANGE3_STEP    = 13'h0014; // 20 mV

	// ========================================
	// Carrier types
	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} blvr_req_t;

	typedef struct packed {
		logic       valid;
		logic       hit;
		logic [7:0] rdata;
	} blvr_rsp_t;

	// Target in half-millivolts so the 5 mV range stays exact
	typedef struct packed {
		logic        floorActive;
		logic [7:0]  code;
		logic [12:0] halfMv;
	} blvr_vtarget_t;

endpackage : blvr_pkg

// *** src/blvr_limit_decode.sv ***
// Registered decode of one 3-bit current-limit code to milliamps
`timescale 1ns/1ps
module blvr_limit_decode
	import blvr_pkg::*;
(
	// Clocking
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        clkEn,
	// Code in, limit out
	input  wire logic [2:0]  limitCode,
	output logic      [12:0] limitMa
);

	// ========================================
	// Decode
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			limitMa <= 13'h1388;
		end else if (clkEn) begin
			limitMa <= 13'(LIMIT_BASE_MA + 13'(limitCode) * LIMIT_STEP_MA);
		end
	end

endmodule : blvr_limit_decode

// *** src/blvr_regs.sv ***
// Current-limit and output-voltage register bank with live decode
`timescale 1ns/1ps

// How it works
// - Limit code bits 5:3, reset all ones
// - Limit decodes 1.5 A plus 0.5 A steps
// - New limit codes apply immediately while running
// - Main voltage code eight bits, reset 0x61
// - Codes 0x00-0x17: 0.5 V plus 10 mV
// - Codes 0x18-0x9D: 0.735 V, 5 mV steps
// - Codes 0x9E-0xFF: 1.42 V, 20 mV steps
// - Pin high selects main, low floor
module blvr_regs
	import blvr_pkg::*;
(
	// Clocking
	input  wire logic          ref_clk,
	input  wire logic          reset_n,
	input  wire logic          clkEn,
	// Register access from the serial interface
	input  wire blvr_req_t     req,
	output blvr_rsp_t          rsp,
	// Enable pins and roof/floor selection
	input  wire logic          first_enable_pin,
	input  wire logic          second_enable_pin,
	input  wire logic          pinSelectSecond,
	input  wire logic          pin_selects_high_low_target,
	// Converter controls
	output logic [2:0]         core1_current_limit_code,
	output logic [2:0]         core2_current_limit_code,
	output logic [2:0]         core3_current_limit_code,
	output logic [12:0]        core1LimitMa,
	output logic [12:0]        core2LimitMa,
	output logic [12:0]        core3LimitMa,
	output blvr_vtarget_t      core0Target
);

	// ========================================
	// Storage
	logic [7:0] limitCtrl [NUM_LIMIT_REGS];
	logic [7:0] core0_voltage_code;
	logic [7:0] core0_floor_voltage_code;
	logic [1:0] pin1Sync;
	logic [1:0] pin2Sync;
	logic [7:0] next_rdata;
	logic       next_hit;
	logic [7:0] selCode;
	logic       floorSel;

	function automatic logic [7:0] limitAddr(input int idx);
		unique case (idx)
			0:       limitAddr = CORE1_LIMIT_ADDR;
			1:       limitAddr = CORE2_LIMIT_ADDR;
			default: limitAddr = CORE3_LIMIT_ADDR;
		endcase
	endfunction : limitAddr

	// Three-range code to half-millivolts
	function automatic logic [12:0] voltHalfMv(input logic [7:0] code);
		logic [12:0] off;
		off = 13'h0000;
		if (code <= VRANGE1_LAST) begin
			off        = 13'(code);
			voltHalfMv = 13'((VRANGE1_BASE_UV + off * VRANGE1_STEP) << 1);
		end else if (code <= VRANGE2_LAST) begin
			off        = 13'(code - VRANGE2_FIRST);
			voltHalfMv = 13'(VRANGE2_BASE_X2 + off * VRANGE2_STEP_X2);
		end else begin
			off        = 13'(code - VRANGE3_FIRST);
			voltHalfMv = 13'((VRANGE3_BASE + off * VRANGE3_STEP) << 1);
		end
	endfunction : voltHalfMv

	// ========================================
	// Limit control registers, whole byte stored
	generate
		for (genvar i = 0; i < NUM_LIMIT_REGS; i++) begin : gLimit
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					limitCtrl[i] <= LIMIT_CTRL_RESET;
				end else if (clkEn && req.write && req.addr == limitAddr(i)) begin
					// No enable gating: takes effect while running
					limitCtrl[i] <= req.wdata;
				end
			end
		end
	endgenerate

	// ========================================
	// Voltage registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core0_voltage_code <= VOUT_RESET;
		end else if (clkEn && req.write && req.addr == CORE0_VOUT_ADDR) begin
			core0_voltage_code <= req.wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core0_floor_voltage_code <= FLOOR_RESET;
		end else if (clkEn && req.write && req.addr == CORE0_FLOOR_ADDR) begin
			core0_floor_voltage_code <= req.wdata;
		end
	end

	// ========================================
	// Read path
	always_comb begin
		next_hit   = 1'b1;
		next_rdata = 8'h00;
		unique case (req.addr)
			CORE1_LIMIT_ADDR: next_rdata = limitCtrl[0];
			CORE2_LIMIT_ADDR: next_rdata = limitCtrl[1];
			CORE3_LIMIT_ADDR: next_rdata = limitCtrl[2];
			CORE0_VOUT_ADDR:  next_rdata = core0_voltage_code;
			CORE0_FLOOR_ADDR: next_rdata = core0_floor_voltage_code;
			default:          next_hit   = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp <= '0;
		end else if (clkEn) begin
			rsp.valid <= req.read;
			rsp.hit   <= req.read & next_hit;
			rsp.rdata <= req.read ? next_rdata : 8'h00;
		end
	end

	// ========================================
	// Enable pin synchronisers, pins are asynchronous
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin1Sync <= 2'h0;
			pin2Sync <= 2'h0;
		end else if (clkEn) begin
			pin1Sync <= {pin1Sync[0], first_enable_pin};
			pin2Sync <= {pin2Sync[0], second_enable_pin};
		end
	end

	// ========================================
	// Target selection
	always_comb begin
		floorSel = pin_selects_high_low_target &&
			!(pinSelectSecond ? pin2Sync[1] : pin1Sync[1]);
		selCode  = floorSel ? core0_floor_voltage_code : core0_voltage_code;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core0Target <= '{floorActive: 1'b0, code: VOUT_RESET, halfMv: 13'h0000};
		end else if (clkEn) begin
			core0Target.floorActive <= floorSel;
			core0Target.code        <= selCode;
			core0Target.halfMv      <= voltHalfMv(selCode);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core1_current_limit_code <= 3'h7;
			core2_current_limit_code <= 3'h7;
			core3_current_limit_code <= 3'h7;
		end else if (clkEn) begin
			core1_current_limit_code <= limitCtrl[0][LIMIT_MSB:LIMIT_LSB];
			core2_current_limit_code <= limitCtrl[1][LIMIT_MSB:LIMIT_LSB];
			core3_current_limit_code <= limitCtrl[2][LIMIT_MSB:LIMIT_LSB];
		end
	end

	// ========================================
	// Limit decoders
	blvr_limit_decode uDec1 (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.clkEn     (clkEn),
		.limitCode (limitCtrl[0][LIMIT_MSB:LIMIT_LSB]),
		.limitMa   (core1LimitMa)
	);
	blvr_limit_decode uDec2 (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.clkEn     (clkEn),
		.limitCode (limitCtrl[1][LIMIT_MSB:LIMIT_LSB]),
		.limitMa   (core2LimitMa)
	);
	blvr_limit_decode uDec3 (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.clkEn     (clkEn),
		.limitCode (limitCtrl[2][LIMIT_MSB:LIMIT_LSB]),
		.limitMa   (core3LimitMa)
	);

endmodule : blvr_regs

// *** verification/blvr_host_model.sv ***
// Host model: register reads and writes on the request port
`timescale 1ns/1ps
module blvr_host_model
	import blvr_pkg::*;
(
	// Clocking
	input wire logic      ref_clk,
	// Register access
	output blvr_req_t     req,
	input wire blvr_rsp_t rsp
);
	initial req = '0;
	// ========================================
	// Strobes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk) req <= '{1'b1, 1'b0, a, d};
		@(negedge ref_clk) req <= '0;
	endtask : wr
	// Response stands one cycle only, so take it on the first falling edge after the strobe
	task automatic rd(input logic [7:0] a, output blvr_rsp_t r);
		@(negedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge ref_clk);
		r = rsp;
		req <= '0;
	endtask : rd
	// Reserved bits go back as read
	task automatic set_limit(input logic [7:0] a, input logic [2:0] c);
		blvr_rsp_t r;
		rd(a, r);
		wr(a, {r.rdata[7:6], c, r.rdata[2:0]});
	endtask : set_limit
endmodule : blvr_host_model

// *** verification/blvr_regs_monitor.sv ***
// Checker: assertions on the limit and voltage bank ports
`timescale 1ns/1ps
module blvr_regs_monitor
	import blvr_pkg::*;
(
	// Clocking
	input wire logic          ref_clk,
	input wire logic          reset_n,
	input wire logic          clkEn,
	// Bus and selection
	input wire blvr_req_t     req,
	input wire blvr_rsp_t     rsp,
	input wire logic          pin_selects_high_low_target,
	// Outputs
	input wire logic [2:0]    core1_current_limit_code,
	input wire logic [12:0]   core1LimitMa,
	input wire blvr_vtarget_t core0Target
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ========================================
	// Shadows of the two voltage codes
	logic [7:0] mainCode;
	logic [7:0] floorCode;
	logic [2:0] wrLimit;
	assign wrLimit = req.wdata[5:3];
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mainCode  <= 8'h61;
			floorCode <= 8'h00;
		end else if (clkEn && req.write) begin
			if (req.addr == 8'h0A) mainCode <= req.wdata;
			if (req.addr == 8'h0B) floorCode <= req.wdata;
		end
	end
	function automatic logic [12:0] half_mv(input logic [7:0] c);
		if (c <= 8'h17) return 13'h03E8 + 13'(c) * 13'h0014;
		if (c <= 8'h9D) return 13'h05BE + 13'(c - 8'h18) * 13'h000A;
		return 13'h0B18 + 13'(c - 8'h9E) * 13'h0028;
	endfunction : half_mv
	// ========================================
	// Assertions
	lim_write_a: assert property (
		clkEn && req.write && req.addr == 8'h05 |-> ##2 core1_current_limit_code == $past(wrLimit, 2))
		else $error("limit code not taken");
	lim_decode_a: assert property (
		core1LimitMa == 13'h05DC + 13'h01F4 * 13'(core1_current_limit_code))
		else $error("limit decode wrong");
	main_code_a: assert property (
		$past(clkEn) && !core0Target.floorActive |-> core0Target.code == $past(mainCode))
		else $error("main code wrong");
	floor_code_a: assert property (
		$past(clkEn) && core0Target.floorActive |-> core0Target.code == $past(floorCode))
		else $error("floor code wrong");
	floor_sel_a: assert property (
		$past(clkEn) && core0Target.floorActive |-> $past(pin_selects_high_low_target))
		else $error("floor without pin mode");
	volt_decode_a: assert property (
		$past(reset_n) |-> core0Target.halfMv == half_mv(core0Target.code))
		else $error("voltage decode wrong");
	main_read_a: assert property (
		clkEn && req.read && req.addr == 8'h0A |=> rsp.valid && rsp.hit && rsp.rdata == $past(mainCode))
		else $error("main readback wrong");
	unmapped_a: assert property (
		clkEn && req.read && !(req.addr inside {8'h05, 8'h07, 8'h09, 8'h0A, 8'h0B})
		|=> rsp.valid && !rsp.hit && rsp.rdata == 8'h00) else $error("unmapped read hit");
endmodule : blvr_regs_monitor
bind blvr_regs blvr_regs_monitor mon (.ref_clk, .reset_n, .clkEn, .req, .rsp,
	.pin_selects_high_low_target, .core1_current_limit_code, .core1LimitMa, .core0Target);

// *** verification/tb_top.sv ***
// Testbench: reset values, limits, voltage ranges, roof/floor choice
`timescale 1ns/1ps
module tb_top
	import blvr_pkg::*;
;
	logic          ref_clk   = 1'b0;
	logic          reset_n   = 1'b0;
	logic          clkEn     = 1'b1;
	logic          enPin1    = 1'b0;
	logic          enPin2    = 1'b0;
	logic          selSecond = 1'b0;
	logic          roofFloor = 1'b0;
	blvr_req_t     req;
	blvr_rsp_t     rsp;
	logic [2:0]    lim [3];
	logic [12:0]   limMa [3];
	blvr_vtarget_t tgt;
	int            n_fail    = 0;
	int            tests_run = 0;
	blvr_regs uut (.ref_clk, .reset_n, .clkEn, .req, .rsp,
		.first_enable_pin(enPin1), .second_enable_pin(enPin2), .pinSelectSecond(selSecond),
		.pin_selects_high_low_target(roofFloor), .core1_current_limit_code(lim[0]),
		.core2_current_limit_code(lim[1]), .core3_current_limit_code(lim[2]),
		.core1LimitMa(limMa[0]), .core2LimitMa(limMa[1]), .core3LimitMa(limMa[2]),
		.core0Target(tgt));
	blvr_host_model host (.ref_clk, .req, .rsp);
	initial forever #20 ref_clk = ~ref_clk;
	// ========================================
	// Checks and verdict
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	// ========================================
	// Scenarios
	task automatic t_reset();
		blvr_rsp_t  r;
		logic [7:0] a [6] = '{8'h05, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h06};
		logic [7:0] e [6] = '{8'h3A, 8'h3A, 8'h3A, 8'h61, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			host.rd(a[i], r);
			chk("reset value", {4'h0, i < 5, e[i]}, {4'h0, r.hit, r.rdata});
		end
		chk("reset limit", 13'h1388, limMa[2]);
		$display("reset test done");
	endtask : t_reset
	task automatic t_limit();
		blvr_rsp_t r;
		for (int n = 0; n < 3; n++) begin
			for (int c = 0; c < 8; c++) begin
				host.set_limit(8'h05 + 8'(2 * n), 3'(c));
				@(negedge ref_clk);
				chk("limit code", 13'(c), 13'(lim[n]));
				chk("limit mA", 13'h05DC + 13'h01F4 * 13'(c), limMa[n]);
			end
			host.rd(8'h05 + 8'(2 * n), r);
			chk("limit reg", 13'h003A, 13'(r.rdata));
		end
		$display("limit test done");
	endtask : t_limit
	task automatic t_vout();
		logic [7:0]  v [7] = '{8'h00, 8'h17, 8'h18, 8'h61, 8'h9D, 8'h9E, 8'hFF};
		logic [12:0] h [7] = '{13'h03E8, 13'h05B4, 13'h05BE, 13'h0898, 13'h0AF0, 13'h0B18, 13'h1A40};
		for (int i = 0; i < 7; i++) begin
			host.wr(8'h0A, v[i]);
			@(negedge ref_clk);
			chk("main code", 13'(v[i]), 13'(tgt.code));
			chk("target halfMv", h[i], tgt.halfMv);
		end
		$display("voltage test done");
	endtask : t_vout
	task automatic t_floor();
		host.wr(8'h0B, 8'h9E);
		roofFloor <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			selSecond <= s[0];
			{enPin2, enPin1} <= s[0] ? 2'b01 : 2'b10;
			repeat (4) @(negedge ref_clk);
			chk("floor target", 13'h019E, 13'({tgt.floorActive, tgt.code}));
			{enPin2, enPin1} <= s[0] ? 2'b10 : 2'b01;
			repeat (4) @(negedge ref_clk);
			chk("roof target", 13'h00FF, 13'({tgt.floorActive, tgt.code}));
		end
		$display("floor test done");
	endtask : t_floor
	// Write while the clock enable is low must be dropped
	task automatic t_freeze();
		blvr_rsp_t r;
		clkEn <= 1'b0;
		host.wr(8'h0A, 8'h20);
		repeat (3) @(negedge ref_clk);
		chk("frozen target", 13'h00FF, 13'(tgt.code));
		clkEn <= 1'b1;
		host.rd(8'h0A, r);
		chk("frozen write", 13'h00FF, 13'(r.rdata));
		$display("freeze test done");
	endtask : t_freeze
	// Guard against a hang
	initial begin
		#200000;
		n_fail++;
		results();
	end
	initial begin
		repeat (10) @(negedge ref_clk);
		reset_n <= 1'b1;
		@(negedge ref_clk);
		t_reset();
		t_limit();
		t_vout();
		t_floor();
		t_freeze();
		results();
	end
endmodule : tb_top
